// ==== hdl/tsp_debug_ctrl.sv ====
// test strap, debug test point, shared address pin and projector power control
// assumes AXI4-Lite master on clk_sys, pin inputs synchronous, pads resolve out/oe
`timescale 1ns/1ps
module tsp_debug_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // strap and test pins
  input  wire logic        powerOnSense,
  input  wire logic        boardTestTristate,
  input  wire logic [7:0]  testPointIn,
  output logic [7:0]       testPointOut,
  output logic [7:0]       testPointOe,
  input  wire logic [7:0]  debugSignals,     // cpu ready, memory select, trans, flash ready, req, accept, done, gate
  // scan outputs exempt from board test tristate
  input  wire logic        scanDataFirst,
  input  wire logic        scanDataSecond,
  output logic             scanOutFirst,
  output logic             scanOutFirstOe,
  output logic             scanOutSecond,
  output logic             scanOutSecondOe,
  // shared gpio / program memory address pins
  input  wire logic        progMemAddrBit21,
  input  wire logic        progMemAddrBit22,
  input  wire logic [1:0]  sharedPinIn,      // bit 0 lower pin, bit 1 upper pin
  output logic [1:0]       sharedPinOut,
  output logic [1:0]       sharedPinOe,
  // projector power control
  input  wire logic        projectorOn,
  output logic             projPowerEn,
  output logic             projImageEn,
  output logic             padOutputEn      // enable for every other output pad
);
  import tsp_pkg::*;

  tsp_tp_if tpBus ();

  // AXI state
  logic        awHave_ff, nxt_awHave;
  logic [3:0]  awAddr_ff, nxt_awAddr;
  logic        wHave_ff,  nxt_wHave;
  logic [31:0] wData_ff,  nxt_wData;
  logic [3:0]  wStrb_ff,  nxt_wStrb;
  logic        bValid_ff, nxt_bValid;
  logic [1:0]  bResp_ff,  nxt_bResp;
  logic        rValid_ff, nxt_rValid;
  logic [1:0]  rResp_ff,  nxt_rResp;
  logic [31:0] rData_ff,  nxt_rData;
  // registers
  logic [31:0] ctrl_ff,   nxt_ctrl;
  logic [23:0] tpSel_ff,  nxt_tpSel;
  // pins
  logic [1:0]  shOut_ff,  nxt_shOut;
  logic [1:0]  shOe_ff,   nxt_shOe;
  logic        scan1_ff,  nxt_scan1;
  logic        scan2_ff,  nxt_scan2;
  // projector
  tsp_proj_t   proj_ff,   nxt_proj;
  logic [4:0]  pjCnt_ff,  nxt_pjCnt;

  logic        wrFire;
  logic        rdFire;
  logic [31:0] statusWord;
  logic [31:0] ctrlWide;
  tsp_flash_t  flashSize;

  // handshakes: accept channels only while ce runs and no response is pending
  assign s_axi_awready = ce && !awHave_ff && !bValid_ff;
  assign s_axi_wready  = ce && !wHave_ff && !bValid_ff;
  assign s_axi_arready = ce && !rValid_ff;
  assign wrFire        = awHave_ff && wHave_ff && !bValid_ff;
  assign rdFire        = s_axi_arvalid && s_axi_arready;
  assign flashSize     = tsp_flash_t'(ctrl_ff[CTRL_FLASH_LSB +: 2]);

  // status word built from live block state
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[STAT_STRAP_LSB +: 8] = tpBus.strap;
    statusWord[STAT_DEBUG]          = tpBus.debugMode;
    statusWord[STAT_PROJ_LSB +: 2]  = proj_ff;
    statusWord[STAT_GPIO_LSB +: 2]  = sharedPinIn;
    statusWord[STAT_PROJECTOR_ON]        = projectorOn;
  end

  // next state of the bus slave and the writable registers
  always_comb begin
    nxt_awHave = awHave_ff;
    nxt_awAddr = awAddr_ff;
    nxt_wHave  = wHave_ff;
    nxt_wData  = wData_ff;
    nxt_wStrb  = wStrb_ff;
    nxt_bValid = bValid_ff;
    nxt_bResp  = bResp_ff;
    nxt_rValid = rValid_ff;
    nxt_rResp  = rResp_ff;
    nxt_rData  = rData_ff;
    nxt_ctrl   = ctrl_ff;
    nxt_tpSel  = tpSel_ff;
    ctrlWide   = 32'h0000_0000;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_awHave = 1'b1;
      nxt_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_wHave = 1'b1;
      nxt_wData = s_axi_wdata;
      nxt_wStrb = s_axi_wstrb;
    end
    if (wrFire) begin
      nxt_awHave = 1'b0;
      nxt_wHave  = 1'b0;
      nxt_bValid = 1'b1;
      nxt_bResp  = RESP_OKAY;
      case ({awAddr_ff[3:2], 2'b00})
        ADDR_CTRL: begin
          nxt_ctrl = tsp_apply_strb(ctrl_ff, wData_ff, wStrb_ff) & CTRL_MASK;
        end
        ADDR_TPSEL: begin
          ctrlWide  = tsp_apply_strb({8'h00, tpSel_ff}, wData_ff, wStrb_ff);
          nxt_tpSel = ctrlWide[23:0];
        end
        ADDR_STATUS: begin
          nxt_bResp = RESP_OKAY;                            // read-only, write ignored
        end
        default: begin
          nxt_bResp = RESP_SLVERR;
        end
      endcase
    end else if (bValid_ff && s_axi_bready) begin
      nxt_bValid = 1'b0;
    end
    if (rdFire) begin
      nxt_rValid = 1'b1;
      nxt_rResp  = RESP_OKAY;
      case ({s_axi_araddr[3:2], 2'b00})
        ADDR_CTRL:   nxt_rData = ctrl_ff;
        ADDR_TPSEL:  nxt_rData = {8'h00, tpSel_ff};
        ADDR_STATUS: nxt_rData = statusWord;
        default: begin
          nxt_rData = 32'h0000_0000;
          nxt_rResp = RESP_SLVERR;
        end
      endcase
    end else if (rValid_ff && s_axi_rready) begin
      nxt_rValid = 1'b0;
    end
  end

  // bus slave and register flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      awHave_ff <= 1'b0;
      awAddr_ff <= 4'h0;
      wHave_ff  <= 1'b0;
      wData_ff  <= 32'h0000_0000;
      wStrb_ff  <= 4'h0;
      bValid_ff <= 1'b0;
      bResp_ff  <= RESP_OKAY;
      rValid_ff <= 1'b0;
      rResp_ff  <= RESP_OKAY;
      rData_ff  <= 32'h0000_0000;
      ctrl_ff   <= CTRL_RESET;
      tpSel_ff  <= TPSEL_RESET;
    end else if (ce) begin
      awHave_ff <= nxt_awHave;
      awAddr_ff <= nxt_awAddr;
      wHave_ff  <= nxt_wHave;
      wData_ff  <= nxt_wData;
      wStrb_ff  <= nxt_wStrb;
      bValid_ff <= nxt_bValid;
      bResp_ff  <= nxt_bResp;
      rValid_ff <= nxt_rValid;
      rResp_ff  <= nxt_rResp;
      rData_ff  <= nxt_rData;
      ctrl_ff   <= nxt_ctrl;
      tpSel_ff  <= nxt_tpSel;
    end
  end

  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp  = bResp_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rresp  = rResp_ff;
  assign s_axi_rdata  = rData_ff;

  // shared pin roles by flash size, scan output retiming
  always_comb begin
    nxt_shOut = {ctrl_ff[CTRL_GPIO17_OUT], ctrl_ff[CTRL_GPIO16_OUT]};
    nxt_shOe  = {ctrl_ff[CTRL_GPIO17_OE],  ctrl_ff[CTRL_GPIO16_OE]};
    case (flashSize)
      FLASH_64MB: begin
        nxt_shOut[0] = progMemAddrBit21;
        nxt_shOe[0]  = 1'b1;
      end
      FLASH_128MB: begin
        nxt_shOut = {progMemAddrBit22, progMemAddrBit21};
        nxt_shOe  = 2'b11;
      end
      default: begin
        nxt_shOut = nxt_shOut;                              // gpio roles kept
      end
    endcase
    nxt_scan1 = scanDataFirst;
    nxt_scan2 = scanDataSecond;
  end

  // pin flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shOut_ff <= 2'b00;
      shOe_ff  <= 2'b00;
      scan1_ff <= 1'b0;
      scan2_ff <= 1'b0;
    end else if (ce) begin
      shOut_ff <= nxt_shOut;
      shOe_ff  <= nxt_shOe;
      scan1_ff <= nxt_scan1;
      scan2_ff <= nxt_scan2;
    end
  end

  assign sharedPinOut    = shOut_ff;
  assign sharedPinOe     = shOe_ff & {2{!boardTestTristate}};
  assign scanOutFirst    = scan1_ff;
  assign scanOutFirstOe  = 1'b1;
  assign scanOutSecond   = scan2_ff;
  assign scanOutSecondOe = 1'b1;
  assign padOutputEn     = !boardTestTristate;

  // projector power sequencer
  always_comb begin
    nxt_proj  = proj_ff;
    nxt_pjCnt = pjCnt_ff;
    case (proj_ff)
      PJ_OFF: begin
        if (projectorOn) begin
          nxt_proj  = PJ_RAMP_UP;
          nxt_pjCnt = 5'h00;
        end
      end
      PJ_RAMP_UP: begin
        nxt_pjCnt = pjCnt_ff + 5'h01;
        if (!projectorOn) begin
          nxt_proj  = PJ_RAMP_DOWN;
          nxt_pjCnt = 5'h00;
        end else if (pjCnt_ff == PROJ_SETTLE_LAST) begin
          nxt_proj = PJ_ON;
        end
      end
      PJ_ON: begin
        if (!projectorOn) begin
          nxt_proj  = PJ_RAMP_DOWN;
          nxt_pjCnt = 5'h00;
        end
      end
      PJ_RAMP_DOWN: begin
        nxt_pjCnt = pjCnt_ff + 5'h01;
        if (pjCnt_ff == PROJ_SETTLE_LAST) begin
          nxt_proj = PJ_OFF;
        end
      end
      default: begin
        nxt_proj = PJ_OFF;
      end
    endcase
  end

  // projector flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      proj_ff  <= PJ_OFF;
      pjCnt_ff <= 5'h00;
    end else if (ce) begin
      proj_ff  <= nxt_proj;
      pjCnt_ff <= nxt_pjCnt;
    end
  end

  assign projPowerEn = (proj_ff != PJ_OFF);
  assign projImageEn = (proj_ff == PJ_ON);

  // test point strap and driver
  assign tpBus.powerOnSense      = powerOnSense;
  assign tpBus.boardTestTristate = boardTestTristate;
  assign tpBus.selMap            = tpSel_ff;
  assign tpBus.debugSrc          = debugSignals;

  tsp_test_point tsp_test_point_inst (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .tpIn    (testPointIn),
    .tpOut   (testPointOut),
    .tpOe    (testPointOe),
    .ifc     (tpBus.tp)
  );

  sequence s_on_request;
    ce && proj_ff == PJ_OFF && projectorOn;
  endsequence

  property p_proj_up;
    @(posedge clk_sys) disable iff (rst) s_on_request |=> proj_ff == PJ_RAMP_UP;
  endproperty
  a_proj_up: assert property (p_proj_up) else $error("projector did not start power up");

  property p_proj_down;
    @(posedge clk_sys) disable iff (rst) (ce && proj_ff == PJ_ON && !projectorOn) |=> proj_ff == PJ_RAMP_DOWN;
  endproperty
  a_proj_down: assert property (p_proj_down) else $error("projector did not power down");

  property p_flash128;
    @(posedge clk_sys) disable iff (rst)
      (ce && flashSize == FLASH_128MB) |=> shOut_ff == $past({progMemAddrBit22, progMemAddrBit21}) && shOe_ff == 2'b11;
  endproperty
  a_flash128: assert property (p_flash128) else $error("shared pins not address outputs");

  property p_reset_float;
    @(posedge clk_sys) rst |=> sharedPinOe == 2'b00;
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("shared pin driven after reset");

  property p_sel_write;
    @(posedge clk_sys) disable iff (rst)
      (ce && wrFire && awAddr_ff[3:2] == ADDR_TPSEL[3:2] && wStrb_ff == 4'hF) |=> tpSel_ff == $past(wData_ff[23:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("selection write lost");
endmodule // tsp_debug_ctrl

// ==== hdl/tsp_pkg.sv ====
// shared constants and types for the test strap and debug control block
// assumes a single clk_sys domain at 20 MHz and an AXI4-Lite register port
package tsp_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS   = 50;
  localparam int PROJ_SETTLE_NS  = 800;                                      // power ramp step of the projector
  localparam int PROJ_SETTLE_CYC = (PROJ_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] PROJ_SETTLE_LAST = 5'(PROJ_SETTLE_CYC - 1);

  // register byte addresses
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_TPSEL  = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  // control register fields
  localparam int CTRL_FLASH_LSB  = 0;
  localparam int CTRL_GPIO16_OUT = 2;
  localparam int CTRL_GPIO17_OUT = 3;
  localparam int CTRL_GPIO16_OE  = 4;
  localparam int CTRL_GPIO17_OE  = 5;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK   = 32'h0000_003F;

  // test point selection: 3-bit source index per output, identity by default
  localparam int TP_WIDTH   = 8;
  localparam int SEL_BITS   = 3;
  localparam logic [23:0] TPSEL_RESET = 24'hFA_C688;

  // status register fields
  localparam int STAT_STRAP_LSB = 0;
  localparam int STAT_DEBUG     = 8;
  localparam int STAT_PROJ_LSB  = 9;
  localparam int STAT_GPIO_LSB  = 11;
  localparam int STAT_PROJECTOR_ON   = 13;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // flash size codes held in the control register
  typedef enum logic [1:0] {
    FLASH_32MB  = 2'b00,
    FLASH_64MB  = 2'b01,
    FLASH_128MB = 2'b10,
    FLASH_RSVD  = 2'b11
  } tsp_flash_t;

  // projector power states
  typedef enum logic [1:0] {
    PJ_OFF       = 2'b00,
    PJ_RAMP_UP   = 2'b01,
    PJ_ON        = 2'b10,
    PJ_RAMP_DOWN = 2'b11
  } tsp_proj_t;

  // merge write data into a register under byte strobes
  function automatic logic [31:0] tsp_apply_strb(input logic [31:0] old, input logic [31:0] data,
                                                 input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction
endpackage

// ==== hdl/tsp_tp_if.sv ====
// carrier between the control top and the test point driver
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface tsp_tp_if;
  logic        powerOnSense;   // system reset released while high
  logic        boardTestTristate;
  logic [23:0] selMap;         // per-output source index
  logic [7:0]  debugSrc;       // processor bus debug signal set
  logic [7:0]  strap;          // captured strap value
  logic        debugMode;      // strap bit 0

  modport ctrl (output powerOnSense, output boardTestTristate, output selMap, output debugSrc,
                input strap, input debugMode);
  modport tp (input powerOnSense, input boardTestTristate, input selMap, input debugSrc,
              output strap, output debugMode);
endinterface // tsp_tp_if

// ==== hdl/tsp_test_point.sv ====
// test point strap capture and output driver
// assumes pin inputs synchronous to clk_sys; pads resolve level from out and oe
`timescale 1ns/1ps
module tsp_test_point (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic [tsp_pkg::TP_WIDTH-1:0] tpIn,
  output logic      [tsp_pkg::TP_WIDTH-1:0] tpOut,
  output logic      [tsp_pkg::TP_WIDTH-1:0] tpOe,
  tsp_tp_if.tp                            ifc
);
  import tsp_pkg::*;

  logic       posPrev_ff, nxt_posPrev;
  logic [7:0] strap_ff,   nxt_strap;
  logic [7:0] tpOut_ff,   nxt_tpOut;
  logic       oeOn_ff,    nxt_oeOn;
  logic [7:0] routed;
  logic       posRise;

  // route each output from its selected debug source
  always_comb begin
    routed = 8'h00;
    for (int i = 0; i < TP_WIDTH; i++) begin
      routed[i] = ifc.debugSrc[ifc.selMap[i*SEL_BITS +: SEL_BITS]];
    end
  end

  assign posRise = ifc.powerOnSense && !posPrev_ff;

  // next state: strap capture, output enable, output data
  always_comb begin
    nxt_posPrev = ifc.powerOnSense;
    nxt_strap   = strap_ff;
    if (!ifc.powerOnSense) begin
      nxt_strap = 8'h00;
    end else if (posRise) begin
      nxt_strap = tpIn;
    end
    nxt_oeOn  = ifc.powerOnSense && !posRise;
    nxt_tpOut = 8'h00;
    if (strap_ff[0] && oeOn_ff) begin
      nxt_tpOut = routed;
    end
  end

  // registers, frozen while ce is low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      posPrev_ff <= 1'b0;
      strap_ff   <= 8'h00;
      oeOn_ff    <= 1'b0;
      tpOut_ff   <= 8'h00;
    end else if (ce) begin
      posPrev_ff <= nxt_posPrev;
      strap_ff   <= nxt_strap;
      oeOn_ff    <= nxt_oeOn;
      tpOut_ff   <= nxt_tpOut;
    end
  end

  // pins and status toward the top
  assign tpOut         = tpOut_ff;
  assign tpOe          = {TP_WIDTH{oeOn_ff && !ifc.boardTestTristate}};
  assign ifc.strap     = strap_ff;
  assign ifc.debugMode = strap_ff[0];

  sequence s_released;
    ce && ifc.powerOnSense && posPrev_ff;
  endsequence

  property p_capture;
    @(posedge clk_sys) disable iff (rst) (ce && posRise) |=> strap_ff == $past(tpIn);
  endproperty
  a_capture: assert property (p_capture) else $error("strap not captured at release");

  property p_strap_hold;
    @(posedge clk_sys) disable iff (rst) s_released |=> strap_ff == $past(strap_ff);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed after release");

  property p_inputs_in_reset;
    @(posedge clk_sys) disable iff (rst) (ce && !ifc.powerOnSense) |=> tpOe == 8'h00;
  endproperty
  a_inputs_in_reset: assert property (p_inputs_in_reset) else $error("test point driven in reset");

  property p_quiet;
    @(posedge clk_sys) disable iff (rst) (ce && !strap_ff[0]) |=> tpOut_ff == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("test point toggles in quiet mode");

  property p_debug_route;
    @(posedge clk_sys) disable iff (rst) (ce && strap_ff[0] && oeOn_ff) |=> tpOut_ff == $past(routed);
  endproperty
  a_debug_route: assert property (p_debug_route) else $error("debug set not routed");

  property p_tristate;
    @(posedge clk_sys) disable iff (rst) ifc.boardTestTristate |-> tpOe == 8'h00;
  endproperty
  a_tristate: assert property (p_tristate) else $error("test point driven in board test");
endmodule // tsp_test_point

// ==== test/tsp_power_model.sv ====
// board side of the block: power monitor and strap jumpers on the test points
// assumes the design drives test point pads through out/oe on clk_sys
`timescale 1ns/1ps
module tsp_power_model (
  input  wire logic       clk_sys,
  input  wire logic       powerGood,
  input  wire logic [7:0] jumpers,
  input  wire logic [7:0] tpOut,
  input  wire logic [7:0] tpOe,
  output logic            powerOnSense,
  output logic [7:0]      tpPin
);
  // monitor releases system reset one clock after supplies are good
  always_ff @(posedge clk_sys) begin
    powerOnSense <= powerGood;
  end
  // pad level: device drive wins, else jumper pullup or the internal pulldown
  assign tpPin = (tpOe & tpOut) | (~tpOe & jumpers);
endmodule // tsp_power_model

// ==== test/test_strap_debug_control_tb.sv ====
// self-checking bench for the test strap and debug control block
// assumes the power model on the strap pins and an AXI4-Lite master in this bench
`timescale 1ns/1ps
module test_strap_debug_control_tb;
  import tsp_pkg::*;
  logic        clk_sys = 1'h0, rst = 1'h1, ce = 1'h1, powerGood = 1'h0;
  logic        boardTestTristate = 1'h0, projectorOn = 1'h0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr, sharedPinOut, sharedPinOe, sharedPinIn = 2'h1;
  logic [7:0]  jumpers = 8'h00, debugSignals = 8'h2D, testPointIn, testPointOut, testPointOe;
  logic        powerOnSense, scanDataFirst = 1'h0, scanDataSecond = 1'h1;
  logic        scanOutFirst, scanOutFirstOe, scanOutSecond, scanOutSecondOe;
  logic        progMemAddrBit21 = 1'h1, progMemAddrBit22 = 1'h0, projPowerEn, projImageEn, padOutputEn;
  logic [7:0]  flashCtrl [3] = '{8'h38, 8'h01, 8'h02};
  logic [3:0]  flashExp [3] = '{4'hE, 4'h5, 4'hD};
  int          failures = 0, checksDone = 0;

  tsp_debug_ctrl tsp_debug_ctrl_inst (.clk_sys, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .powerOnSense, .boardTestTristate, .testPointIn, .testPointOut, .testPointOe, .debugSignals,
    .scanDataFirst, .scanDataSecond, .scanOutFirst, .scanOutFirstOe, .scanOutSecond, .scanOutSecondOe,
    .progMemAddrBit21, .progMemAddrBit22, .sharedPinIn, .sharedPinOut, .sharedPinOe, .projectorOn,
    .projPowerEn, .projImageEn, .padOutputEn);
  tsp_power_model tsp_power_model_inst (.clk_sys, .powerGood, .jumpers, .tpOut(testPointOut),
    .tpOe(testPointOe), .powerOnSense, .tpPin(testPointIn));

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // wait n rising edges, then settle at the falling edge
  task automatic at(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // write one word; entered just after a rising edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    aw = 1'h1;
    w = 1'h1;
    while (aw || w) begin
      @(negedge clk_sys);
      if (s_axi_awready === 1'h1) aw = 1'h0;
      if (s_axi_wready === 1'h1) w = 1'h0;
      @(posedge clk_sys);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do begin
      @(negedge clk_sys);
    end while (s_axi_bvalid !== 1'h1);
    chk("write response", {30'h0, RESP_OKAY}, {30'h0, s_axi_bresp});
    @(posedge clk_sys);
    s_axi_bready <= 1'h0;
    @(posedge clk_sys);                                   // idle edge before the next request
  endtask
  // read one word; entered just after a rising edge
  task automatic axiRd(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clk_sys);
    end while (s_axi_arready !== 1'h1);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'h0;
    do begin
      @(negedge clk_sys);
    end while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge clk_sys);
    s_axi_rready <= 1'h0;
    @(posedge clk_sys);                                   // idle edge before the next request
  endtask
  // read and compare under a mask
  task automatic rdChk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    axiRd(a);
    chk(nm, e, rd & m);
  endtask
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    repeat (4000) @(posedge clk_sys);
    failures++;
    summarize();
  end

  // test sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    rdChk(ADDR_CTRL, 32'hFFFF_FFFF, CTRL_RESET, "ctrl");
    rdChk(ADDR_TPSEL, 32'hFFFF_FFFF, {8'h00, TPSEL_RESET}, "tpsel");
    at(1);
    chk("pins at reset", 32'h0, {22'h0, testPointOe, sharedPinOe});
    $display("test reset done");
    // all-low strap gives quiet low outputs
    @(posedge clk_sys);
    powerGood <= 1'h1;
    at(6);
    chk("quiet out", 32'hFF00, {16'h0, testPointOe, testPointOut});
    @(posedge clk_sys);
    powerGood <= 1'h0;
    at(3);
    chk("oe in reset", 32'h0, {24'h0, testPointOe});
    @(posedge clk_sys);
    rdChk(ADDR_STATUS, 32'h1FF, 32'h0, "strap cleared");
    $display("test quiet done");
    // debug strap, jumpers moved after capture
    jumpers <= 8'h01;
    powerGood <= 1'h1;
    at(4);
    @(posedge clk_sys);
    jumpers <= 8'hFE;
    rdChk(ADDR_STATUS, 32'h1FF, 32'h101, "strap debug");
    at(1);
    chk("debug route", 32'hFF2D, {16'h0, testPointOe, testPointOut});
    @(posedge clk_sys);
    wr(ADDR_TPSEL, 32'h0005_3977);
    at(3);
    chk("reselect", 32'hB4, {24'h0, testPointOut});
    $display("test debug done");
    // shared pins per flash size
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      wr(ADDR_CTRL, {24'h0, flashCtrl[i]});
      at(2);
      chk("shared pins", {28'h0, flashExp[i]}, {28'h0, sharedPinOe, sharedPinOut & sharedPinOe});
    end
    $display("test flash done");
    // board test float keeps scan outputs alive
    @(posedge clk_sys);
    boardTestTristate <= 1'h1;
    at(1);
    chk("float", 32'hD, {18'h0, testPointOe, sharedPinOe, padOutputEn, scanOutFirstOe, scanOutSecondOe,
        scanOutFirst, scanOutSecond});
    @(posedge clk_sys);
    boardTestTristate <= 1'h0;
    $display("test float done");
    // clock enable low freezes the sequencer
    ce <= 1'h0;
    projectorOn <= 1'h1;
    at(3);
    chk("frozen", 32'h0, {30'h0, projPowerEn, projImageEn});
    @(posedge clk_sys);
    ce <= 1'h1;
    // projector power up then down
    at(5);
    chk("ramp up", 32'h2, {30'h0, projPowerEn, projImageEn});
    at(16);
    chk("image on", 32'h3, {30'h0, projPowerEn, projImageEn});
    @(posedge clk_sys);
    rdChk(ADDR_STATUS, 32'h3E00, 32'h2C00, "status on");
    projectorOn <= 1'h0;
    at(4);
    chk("ramp down", 32'h2, {30'h0, projPowerEn, projImageEn});
    at(20);
    chk("power off", 32'h0, {30'h0, projPowerEn, projImageEn});
    $display("test projector done");
    // unmapped address
    @(posedge clk_sys);
    axiRd(4'hC);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    chk("unmapped data", 32'h0, rd);
    $display("test unmapped done");
    summarize();
  end
endmodule // test_strap_debug_control_tb
